// ### design/mdt_defs.svh
`ifndef MDT_DEFS_SVH
`define MDT_DEFS_SVH
// register offsets (byte index on the plain port)
`define MDT_OFS_STATUS_CONTROL 3'h0
`define MDT_OFS_CLOCK_CONFIG   3'h1
`define MDT_OFS_COUNT_HIGH     3'h2
`define MDT_OFS_COUNT_LOW      3'h3
`define MDT_OFS_LIMIT_HIGH     3'h4
`define MDT_OFS_LIMIT_LOW      3'h5
// status/control fields
`define MDT_BIT_OVF            7
`define MDT_BIT_IRQ_EN         6
`define MDT_BIT_CLEAR          5
`define MDT_BIT_HALT           4
// clock config fields
`define MDT_CLK_SRC_HI         5
`define MDT_CLK_SRC_LO         4
`define MDT_PRE_HI             3
`define MDT_PRE_LO             0
// reset values and top prescaler code
`define MDT_RST_CLK_SRC        2'h0
`define MDT_RST_PRESCALE       4'h0
`define MDT_RST_HALT           1'b1
`define MDT_RST_COUNT          16'h0000
`define MDT_RST_LIMIT          16'h0000
`define MDT_PRE_MAX_CODE       4'h8
`endif

// ### design/mdt_pkg.sv
package mdt_pkg;
  typedef enum logic [1:0] {
    MDT_SRC_BUS      = 2'b00,
    MDT_SRC_FIXED    = 2'b01,
    MDT_SRC_EXT_FALL = 2'b10,
    MDT_SRC_EXT_RISE = 2'b11
  } mdt_src_t;
  typedef enum logic [1:0] {
    MDT_RUN   = 2'b00,
    MDT_WAIT  = 2'b01,
    MDT_STOP  = 2'b10,
    MDT_DEBUG = 2'b11
  } mdt_mode_t;
endpackage : mdt_pkg

// ### design/mdt_modulo_timer.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "mdt_defs.svh"
// Function
// - 16-bit counter wraps to zero after modulo match
// - free-running or modulo limited counting
// - overflow flag bit 7 set on wrap
// - clear flag: read while set, write 0
// - clear bit resets count, flag, loads modulo
// - enable bit 6 gates flag to interrupt
// - halt bit 4 holds count, reset sets
// - status bits 3:0 read zero
// - four clock sources selectable
// - prescaler divides by 1 to 256
// - counts in wait, interrupt wakes processor
// - frozen in stop, never wakes
// - deep stop or reset exit restores reset state
// - debug mode freezes counter, resumes later
// - external clock synchronised before edge detect
// - compare match presented as output
// - source select resets 00, keeps count
// - codes above 1000 divide by 256
// - counter byte reads latched coherently
module mdt_modulo_timer
  import mdt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       fixed_freq_clock_i,
  input  wire logic       ext_count_clock_in_i,
  input  wire logic [1:0] power_mode_i,
  input  wire logic       deep_stop_wake_i,
  output logic            irq_o,
  output logic            wake_o,
  output logic            match_o
);

  if (CNT_W != 16) begin : g_bad_width
    $error("mdt_modulo_timer: only a 16-bit counter is supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic            rst_meta;
  logic            rst_sync;
  logic            deep_rst;
  mdt_mode_t       mode;
  logic            frozen;
  logic            debug;
  logic            ovf_flag;
  logic            irq_en;
  logic            halt;
  logic [1:0]      clk_src;
  logic [3:0]      prescale;
  logic [15:0]     count;
  logic [15:0]     limit_pend;
  logic [15:0]     limit_act;
  logic [7:0]      pre_cnt;
  logic            ext_meta;
  logic            ext_s1;
  logic            ext_s2;
  logic            fix_s1;
  logic            fix_s2;
  logic            fix_s3;
  logic            src_tick;
  logic            pre_tick;
  logic            cnt_tick;
  logic            at_limit;
  logic            wrap;
  logic            flag_seen;
  logic            latch_full;
  logic [15:0]     latch_val;
  logic            wr_sc;
  logic            clr_wr;
  logic [7:0]      next_rdata;
  logic [7:0]      pre_mask;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign mode     = mdt_mode_t'(power_mode_i);
  assign debug    = (mode == MDT_DEBUG);
  assign frozen   = (mode == MDT_STOP) || debug;
  assign deep_rst = deep_stop_wake_i;
  assign wr_sc    = wr_i && (addr_i == `MDT_OFS_STATUS_CONTROL);
  assign clr_wr   = wr_sc && wdata_i[`MDT_BIT_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // clock source edges; fixed clock also sampled, assumed slow vs bus clock
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      ext_meta <= 1'b0;
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
      fix_s1   <= 1'b0;
      fix_s2   <= 1'b0;
      fix_s3   <= 1'b0;
    end else begin
      ext_meta <= ext_count_clock_in_i;
      ext_s1   <= ext_meta;
      ext_s2   <= ext_s1;
      fix_s1   <= fixed_freq_clock_i;
      fix_s2   <= fix_s1;
      fix_s3   <= fix_s2;
    end
  end

  always_comb begin
    case (mdt_src_t'(clk_src))
      MDT_SRC_BUS:      src_tick = 1'b1;
      MDT_SRC_FIXED:    src_tick = fix_s2 && !fix_s3;
      MDT_SRC_EXT_FALL: src_tick = !ext_s1 && ext_s2;
      MDT_SRC_EXT_RISE: src_tick = ext_s1 && !ext_s2;
      default:          src_tick = 1'b0;
    endcase
  end

  // codes past the top ratio saturate at divide by 256
  always_comb begin
    if (prescale >= `MDT_PRE_MAX_CODE) begin
      pre_mask = 8'hff;
    end else begin
      pre_mask = 8'((9'h001 << prescale) - 9'h001);
    end
  end

  assign pre_tick = src_tick && ((pre_cnt & pre_mask) == pre_mask);
  assign cnt_tick = pre_tick && !halt && !frozen;
  assign at_limit = (limit_act == 16'h0000) ? (count == 16'hffff) : (count == limit_act);
  assign wrap     = cnt_tick && at_limit;

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      pre_cnt <= 8'h00;
    end else if (deep_rst || clr_wr) begin
      pre_cnt <= 8'h00;
    end else if (src_tick && !halt && !frozen) begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and modulo
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      count <= `MDT_RST_COUNT;
    end else if (deep_rst || clr_wr) begin
      count <= `MDT_RST_COUNT;
    end else if (wrap) begin
      count <= 16'h0000;
    end else if (cnt_tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      limit_pend <= `MDT_RST_LIMIT;
    end else if (deep_rst) begin
      limit_pend <= `MDT_RST_LIMIT;
    end else if (wr_i && addr_i == `MDT_OFS_LIMIT_HIGH) begin
      limit_pend[15:8] <= wdata_i;
    end else if (wr_i && addr_i == `MDT_OFS_LIMIT_LOW) begin
      limit_pend[7:0] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      limit_act <= `MDT_RST_LIMIT;
    end else if (deep_rst) begin
      limit_act <= `MDT_RST_LIMIT;
    end else if (clr_wr || wrap) begin
      limit_act <= limit_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status/control and clock configuration
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      flag_seen <= 1'b0;
    end else if (deep_rst || wr_sc) begin
      flag_seen <= 1'b0;
    end else if (rd_i && addr_i == `MDT_OFS_STATUS_CONTROL && ovf_flag) begin
      flag_seen <= 1'b1;
    end
  end

  // a wrap in a write-0 clearing cycle keeps the flag set; a clear-bit write still clears it
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      ovf_flag <= 1'b0;
    end else if (deep_rst) begin
      ovf_flag <= 1'b0;
    end else if (wrap && !clr_wr) begin
      ovf_flag <= 1'b1;
    end else if (clr_wr) begin
      ovf_flag <= 1'b0;
    end else if (wr_sc && flag_seen && !wdata_i[`MDT_BIT_OVF]) begin
      ovf_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_en <= 1'b0;
      halt   <= `MDT_RST_HALT;
    end else if (deep_rst) begin
      irq_en <= 1'b0;
      halt   <= `MDT_RST_HALT;
    end else if (wr_sc) begin
      irq_en <= wdata_i[`MDT_BIT_IRQ_EN];
      halt   <= wdata_i[`MDT_BIT_HALT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      clk_src  <= `MDT_RST_CLK_SRC;
      prescale <= `MDT_RST_PRESCALE;
    end else if (deep_rst) begin
      clk_src  <= `MDT_RST_CLK_SRC;
      prescale <= `MDT_RST_PRESCALE;
    end else if (wr_i && addr_i == `MDT_OFS_CLOCK_CONFIG) begin
      clk_src  <= wdata_i[`MDT_CLK_SRC_HI:`MDT_CLK_SRC_LO];
      prescale <= wdata_i[`MDT_PRE_HI:`MDT_PRE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coherent counter read; frozen while debugging
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      latch_full <= 1'b0;
      latch_val  <= 16'h0000;
    end else if (deep_rst || clr_wr) begin
      latch_full <= 1'b0;
    end else if (!debug && rd_i &&
                 (addr_i == `MDT_OFS_COUNT_HIGH || addr_i == `MDT_OFS_COUNT_LOW)) begin
      if (!latch_full) begin
        latch_full <= 1'b1;
        latch_val  <= count;
      end else begin
        latch_full <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      `MDT_OFS_STATUS_CONTROL: next_rdata = {ovf_flag, irq_en, 1'b0, halt, 4'h0};
      `MDT_OFS_CLOCK_CONFIG:   next_rdata = {2'b00, clk_src, prescale};
      `MDT_OFS_COUNT_HIGH:     next_rdata = (latch_full && !debug) ? latch_val[15:8] : count[15:8];
      `MDT_OFS_COUNT_LOW:      next_rdata = (latch_full && !debug) ? latch_val[7:0] : count[7:0];
      `MDT_OFS_LIMIT_HIGH:     next_rdata = limit_pend[15:8];
      `MDT_OFS_LIMIT_LOW:      next_rdata = limit_pend[7:0];
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; stop never raises wake
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_o   <= 1'b0;
      wake_o  <= 1'b0;
      match_o <= 1'b0;
    end else begin
      irq_o   <= ovf_flag && irq_en && !deep_rst;
      wake_o  <= ovf_flag && irq_en && (mode == MDT_WAIT) && !deep_rst;
      match_o <= wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, flag and output checks
  wrap_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    wrap && !clr_wr && !deep_rst |=> count == 16'h0000 && ovf_flag)
    else $error("wrap did not zero count and set flag");
  flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    ovf_flag && !wr_sc && !deep_rst |=> ovf_flag)
    else $error("flag cleared without write");
  flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    wr_sc && flag_seen && !wdata_i[`MDT_BIT_OVF] && !wrap && !deep_rst |=> !ovf_flag)
    else $error("flag not cleared after read and write of zero");
  flag_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    wr_sc && wdata_i[`MDT_BIT_OVF] && !wdata_i[`MDT_BIT_CLEAR] && !deep_rst
    |=> ovf_flag == ($past(ovf_flag) || $past(wrap)))
    else $error("writing one changed the flag");
  clear_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    clr_wr && !deep_rst |=> count == 16'h0000 && !ovf_flag && limit_act == $past(limit_pend))
    else $error("counter clear incomplete");
  irq_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    ##1 irq_o == ($past(ovf_flag) && $past(irq_en) && !$past(deep_rst)))
    else $error("irq mismatch");
  halt_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    halt && !clr_wr && !deep_rst |=> $stable(count))
    else $error("count moved while halted");
  low_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    rd_i && addr_i == `MDT_OFS_STATUS_CONTROL |=> rdata_o[5] == 1'b0 && rdata_o[3:0] == 4'h0)
    else $error("reserved bits nonzero");
  wait_run_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    mode == MDT_WAIT && cnt_tick && !at_limit && !clr_wr && !deep_rst |=> count == $past(count) + 16'h0001)
    else $error("counter idle in wait");
  stop_freeze_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    frozen && !clr_wr && !deep_rst |=> $stable(count) && !wake_o)
    else $error("counter moved in stop or debug");
  deep_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    deep_rst |=> count == `MDT_RST_COUNT && !ovf_flag && !irq_en && halt && limit_act == `MDT_RST_LIMIT
    && clk_src == `MDT_RST_CLK_SRC && prescale == `MDT_RST_PRESCALE)
    else $error("deep stop exit did not restore reset state");
  ext_sync_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    clk_src == MDT_SRC_EXT_RISE && src_tick |-> $past(ext_count_clock_in_i, 2) && !$past(ext_count_clock_in_i, 3))
    else $error("external edge not taken through synchroniser");
  match_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    wrap |=> match_o)
    else $error("match not shown");
  src_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    wr_i && addr_i == `MDT_OFS_CLOCK_CONFIG && !wrap && !deep_rst
    |=> count == $past(count) || count == $past(count) + 16'h0001)
    else $error("clock config write disturbed the count");
  pre_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    prescale >= `MDT_PRE_MAX_CODE && pre_tick && !halt && !frozen && !clr_wr && !deep_rst |=> pre_cnt == 8'h00)
    else $error("prescaler not at full span");
  latch_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    latch_full && !deep_rst |=> $stable(latch_val))
    else $error("latched count changed");
  debug_latch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    debug && !clr_wr && !deep_rst |=> $stable(latch_full) && $stable(latch_val))
    else $error("read latch moved while debugging");
  limit_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    !clr_wr && !wrap && !deep_rst |=> $stable(limit_act))
    else $error("active modulo changed between loads");
  bus_div1_a: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    clk_src == 2'b00 && prescale == 4'h0 && !halt && mode == MDT_RUN && !at_limit && !wr_i && !deep_rst
    |=> count == $past(count) + 16'h0001)
    else $error("no advance at divide by one");

  ////////////////////////////////////////////////////////////////////////////
  // main scenarios
  cover_wrap_c:  cover property (@(posedge clk_sys_i) wrap);
  cover_irq_c:   cover property (@(posedge clk_sys_i) irq_o);
  cover_wake_c:  cover property (@(posedge clk_sys_i) wake_o);
  cover_clear_c: cover property (@(posedge clk_sys_i) ovf_flag ##1 flag_seen ##[1:8] !ovf_flag);
  cover_latch_c: cover property (@(posedge clk_sys_i) latch_full ##[1:20] !latch_full);

endmodule : mdt_modulo_timer

// ### test/tb_top.sv
`timescale 1ns/10ps
`include "mdt_defs.svh"
module tb_top
  import mdt_pkg::*;
;
  localparam logic [2:0] SC = `MDT_OFS_STATUS_CONTROL;
  localparam logic [2:0] CK = `MDT_OFS_CLOCK_CONFIG;
  localparam logic [2:0] CH = `MDT_OFS_COUNT_HIGH;
  localparam logic [2:0] CL = `MDT_OFS_COUNT_LOW;
  localparam logic [2:0] LH = `MDT_OFS_LIMIT_HIGH;
  localparam logic [2:0] LL = `MDT_OFS_LIMIT_LOW;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       fixed_freq_clock_i = 1'b0;
  logic       ext_count_clock_in_i = 1'b0;
  logic [1:0] power_mode_i = 2'h0;
  logic       deep_stop_wake_i = 1'b0;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       wake_o;
  logic       match_o;
  logic       rd_d = 1'b0;
  logic [1:0] fdiv = 2'h0;
  logic [1:0] ediv = 2'h0;
  logic [7:0] lf = 8'h06;
  logic [7:0] exp_q[$];
  int         mismatches = 0;
  int         checks = 0;
  int         cycles = 0;
  int         ext_left = 0;
  int         n;

  mdt_modulo_timer uut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fixed_freq_clock_i(fixed_freq_clock_i), .ext_count_clock_in_i(ext_count_clock_in_i),
    .power_mode_i(power_mode_i), .deep_stop_wake_i(deep_stop_wake_i), .irq_o(irq_o), .wake_o(wake_o),
    .match_o(match_o));

  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fixed clock at bus/4; external clock at bus/8, only while toggles remain
  always @(posedge clk_sys_i) begin
    fdiv <= fdiv + 2'h1;
    if (fdiv[0]) fixed_freq_clock_i <= ~fixed_freq_clock_i;
    if (ext_left > 0) begin
      ediv <= ediv + 2'h1;
      if (ediv == 2'h3) begin
        ext_count_clock_in_i <= ~ext_count_clock_in_i;
        ext_left <= ext_left - 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : cyc

  // strobes drop for one cycle between accesses so no signal is assigned twice per step
  task wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : rd

  // first interval after a config change may be partial, so sync on one match first
  task automatic period(input int want);
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (match_o !== 1'b1 && n < 3000);
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (match_o !== 1'b1 && n < 3000);
    check(16'(n), 16'(want), "match period");
  endtask : period

  ////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_d) check({8'h00, rdata_o}, {8'h00, exp_q.pop_front()}, "read data");
    rd_d <= rd_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rstn_i <= 1'b1;
    cyc(3);
    rd(SC, 8'h10);
    for (int a = 1; a < 8; a++) rd(a[2:0], 8'h00);
    wr(CK, 8'h30);
    wr(SC, 8'h20);
    ext_left <= 6;
    cyc(40);
    wr(SC, 8'h10);
    wr(CK, 8'h00);
    rd(CH, 8'h00);
    rd(CL, 8'h03);
    rd(CH, 8'h00);
    wr(SC, 8'h00);
    cyc(10);
    rd(CL, 8'h03);
    wr(SC, 8'h30);
    rd(SC, 8'h10);
    rd(CL, 8'h00);
    rd(CH, 8'h00);
    repeat (4) begin
      lf = lfsr(lf);
      wr(CK, lf);
      rd(CK, lf & 8'h3f);
      lf = lfsr(lf);
      wr(LL, lf);
      rd(LL, lf);
      wr(CL, ~lf);
      wr(3'h6, lf);
      rd(CL, 8'h00);
      rd(3'h6, 8'h00);
    end
    wr(CK, 8'h00);
    wr(LH, 8'h00);
    wr(LL, 8'h05);
    wr(SC, 8'h20);
    period(6);
    for (int m = 2; m < 4; m++) begin
      power_mode_i <= m[1:0];
      cyc(3);
      n = 0;
      repeat (40) begin @(posedge clk_sys_i); if (match_o === 1'b1) n++; end
      check(16'(n), 16'h0000, "frozen matches");
    end
    power_mode_i <= MDT_WAIT;
    period(6);
    wr(SC, 8'h10);
    rd(SC, 8'h90);
    wr(SC, 8'h90);
    rd(SC, 8'h90);
    wr(SC, 8'h10);
    rd(SC, 8'h10);
    wr(SC, 8'h40);
    n = 0;
    while (!(irq_o === 1'b1 && wake_o === 1'b1) && n < 20) begin @(posedge clk_sys_i); n++; end
    check({15'h0, irq_o}, 16'h0001, "irq");
    check({15'h0, wake_o}, 16'h0001, "wake");
    wr(SC, 8'h50);
    rd(SC, 8'hd0);
    wr(SC, 8'h50);
    cyc(3);
    check({15'h0, irq_o}, 16'h0000, "irq after clear");
    power_mode_i <= MDT_STOP;
    wr(CK, 8'h15);
    deep_stop_wake_i <= 1'b1;
    cyc(1);
    deep_stop_wake_i <= 1'b0;
    power_mode_i <= MDT_RUN;
    cyc(1);
    rd(SC, 8'h10);
    rd(CK, 8'h00);
    rd(LL, 8'h00);
    wr(LL, 8'h01);
    for (int p = 0; p < 10; p++) begin
      wr(CK, (p == 9) ? 8'h0f : 8'(p));
      wr(SC, 8'h20);
      period(2 << ((p > 8) ? 8 : p));
    end
    wr(CK, 8'h10);
    wr(SC, 8'h20);
    period(8);
    ext_left <= 200;
    wr(CK, 8'h30);
    period(16);
    wr(CK, 8'h20);
    period(16);
    cyc(3);
    report_and_stop();
  end
endmodule : tb_top
